//--- rtl/pmv_core.v
// program store with vector entry, return stack and table read
// Functional notes
// - program store holds 48K words of 16 bits, for fetch and tables
// - after reset fetching starts at location zero
// - enabled smart card interrupt enters 004H when stack not full
// - enabled usb interrupt enters 008H when stack not full
// - enabled external pin 0 edge enters 00CH when stack not full
// - enabled external pin 1 edge enters 010H when stack not full
// - enabled timer 0 overflow enters 014H when stack not full
// - enabled timer 1 overflow enters 018H when stack not full
// - enabled card insert or removal enters 01CH when stack not full
// - enabled conversion done enters 020H when stack not full
// - 024H shared by serial 0, peripheral pin, time base, clock
// - 028H shared by serial 1, timer 2 and timer 3 overflow
// - shared vector entered only for an enabled contributing source
// - table address is high and low pointer together
// - current-page read uses pointers, last-page read the final page
// - low byte to named data register, high byte to high latch
// - unimplemented high byte bits load as zero
// - last page base BF00H plus low pointer, high pointer ignored
// - high latch read only, changed by table reads alone
// - every table read takes two instruction cycles
// - enabled request on full stack stays pending until a return or a further call
// - interrupt pushes program counter before vector load
`timescale 1ns/10ps
`include "pmv_consts.vh"
module pmv_core #(
  parameter DEPTH       = `PMV_DEPTH,
  parameter STACK_DEPTH = `PMV_STACK_DEPTH,
  parameter HIGH_MASK   = `PMV_HIGH_MASK
) (
  input  wire                      clock,
  input  wire                      rst,
  input  wire                      prog_we,
  input  wire [`PMV_AW-1:0]        prog_addr,
  input  wire [`PMV_DW-1:0]        prog_data,
  input  wire                      insn_boundary,
  input  wire [`PMV_AW-1:0]        next_pc,
  input  wire                      call_op,
  input  wire                      return_op,
  input  wire                      return_from_interrupt_op,
  input  wire [`PMV_NSRC-1:0]      irq_event,
  input  wire [`PMV_NSRC-1:0]      irq_enable,
  input  wire                      tab_cur_op,
  input  wire                      tab_last_op,
  input  wire [7:0]                tab_dest,
  input  wire [7:0]                tbl_ptr_lo,
  input  wire [7:0]                tbl_ptr_hi,
  output reg  [`PMV_AW-1:0]        fetch_addr,
  output reg  [`PMV_DW-1:0]        fetch_word,
  output reg                       irq_ack,
  output reg  [`PMV_AW-1:0]        irq_vector,
  output reg  [`PMV_AW-1:0]        return_pc,
  output reg                       return_valid,
  output reg                       stack_full,
  output wire                      tab_busy,
  output reg                       dmem_we,
  output reg  [7:0]                dmem_addr,
  output reg  [7:0]                dmem_data,
  output reg  [7:0]                table_high_byte_latch
);

  // ****************************************************************
  // program store
  // ****************************************************************
  reg  [`PMV_DW-1:0] mem_q [0:DEPTH-1];
  reg  [3:0]         sel_slot;
  reg  [4:0]         sel_src;
  reg                sel_any;
  wire               can_irq;

  // ****************************************************************
  // source mapping: 0..7 direct, 8..11 group 0, 12..14 group 1
  // 15..17 spare (tie low)
  // ****************************************************************
  wire [`PMV_NSRC-1:0] live_w;
  reg  [`PMV_NSRC-1:0] pend_q;
  genvar g;
  generate
    for (g = 0; g < `PMV_NSRC; g = g + 1) begin : g_pend
      // pending flag kept while stack full; set beats clear
      always @(posedge clock) begin
        if (rst)
          pend_q[g] <= 1'b0;
        else if (irq_event[g])
          pend_q[g] <= 1'b1;
        else if (can_irq && sel_src == g)
          pend_q[g] <= 1'b0;
      end
      assign live_w[g] = pend_q[g] & irq_enable[g];
    end
  endgenerate

  wire [9:0] vec_req_w;
  assign vec_req_w[0] = live_w[0];
  assign vec_req_w[1] = live_w[1];
  assign vec_req_w[2] = live_w[2];
  assign vec_req_w[3] = live_w[3];
  assign vec_req_w[4] = live_w[4];
  assign vec_req_w[5] = live_w[5];
  assign vec_req_w[6] = live_w[6];
  assign vec_req_w[7] = live_w[7];
  assign vec_req_w[8] = |live_w[11:8];
  assign vec_req_w[9] = |live_w[14:12];

  // vector address for a slot
  function [`PMV_AW-1:0] vec_of;
    input [3:0] slot;
    begin
      case (slot)
        4'h0:    vec_of = `PMV_VEC_SCARD;
        4'h1:    vec_of = `PMV_VEC_USB;
        4'h2:    vec_of = `PMV_VEC_EXT0;
        4'h3:    vec_of = `PMV_VEC_EXT1;
        4'h4:    vec_of = `PMV_VEC_TMR0;
        4'h5:    vec_of = `PMV_VEC_TMR1;
        4'h6:    vec_of = `PMV_VEC_CARDDET;
        4'h7:    vec_of = `PMV_VEC_ADC;
        4'h8:    vec_of = `PMV_VEC_MF0;
        4'h9:    vec_of = `PMV_VEC_MF1;
        default: vec_of = `PMV_VEC_RESET;
      endcase
    end
  endfunction

  // first live source within a range, lowest index wins
  function [4:0] first_src;
    input [`PMV_NSRC-1:0] v;
    input [4:0]           lo;
    input [4:0]           hi;
    integer i;
    begin
      first_src = 5'h1F;
      for (i = `PMV_NSRC - 1; i >= 0; i = i - 1)
        if (v[i] && i >= lo && i <= hi)
          first_src = i[4:0];
    end
  endfunction

  integer k;
  always @* begin
    sel_slot = 4'h0;
    sel_any  = 1'b0;
    for (k = 9; k >= 0; k = k - 1)
      if (vec_req_w[k]) begin
        sel_slot = k[3:0];
        sel_any  = 1'b1;
      end
    case (sel_slot)
      4'h8:    sel_src = first_src(live_w, 5'd8, 5'd11);
      4'h9:    sel_src = first_src(live_w, 5'd12, 5'd14);
      default: sel_src = {1'b0, sel_slot};
    endcase
  end

  // ****************************************************************
  // return stack
  // ****************************************************************
  localparam [`PMV_STACK_IW-1:0] STK_TOP = STACK_DEPTH;
  reg  [`PMV_AW-1:0]       stk_q [0:STACK_DEPTH-1];
  reg  [`PMV_STACK_IW-1:0] return_stack_index;
  reg  [`PMV_STACK_IW-1:0] stk_idx_d;
  reg                      stack_full_d;
  wire                     do_ret;
  wire                     can_call;
  wire                     push_w;
  wire                     pop_w;
  wire                     stk_empty_w;

  assign do_ret      = return_op | return_from_interrupt_op;
  assign stk_empty_w = (return_stack_index == {`PMV_STACK_IW{1'b0}});
  // a call or return in the same cycle keeps the interrupt out
  assign can_irq     = sel_any & insn_boundary & ~tab_busy
                       & ~stack_full & ~do_ret & ~call_op;
  // calls still push on a full stack; the index wraps
  assign can_call    = call_op & insn_boundary;
  assign push_w      = can_irq | can_call;
  // a pop on an empty stack is ignored
  assign pop_w       = do_ret & ~push_w & ~stk_empty_w;

  // next index and full flag
  always @* begin
    stk_idx_d    = return_stack_index;
    stack_full_d = stack_full;
    if (push_w) begin
      stk_idx_d    = return_stack_index + 5'd1;
      stack_full_d = (stk_idx_d == STK_TOP);
    end else if (pop_w) begin
      stk_idx_d    = return_stack_index - 5'd1;
      stack_full_d = 1'b0;
    end
  end

  // push lands before the vector is loaded
  always @(posedge clock) begin
    if (!rst && push_w) begin
      stk_q[return_stack_index[3:0]] <= next_pc;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      return_stack_index <= {`PMV_STACK_IW{1'b0}};
      stack_full         <= 1'b0;
    end else begin
      return_stack_index <= stk_idx_d;
      stack_full         <= stack_full_d;
    end
  end

  // pop flags the saved address valid for one cycle; the address holds until the next pop
  always @(posedge clock) begin
    if (rst) begin
      return_valid <= 1'b0;
      return_pc    <= `PMV_VEC_RESET;
    end else begin
      return_valid <= pop_w;
      if (pop_w) begin
        return_pc <= stk_q[return_stack_index[3:0] - 4'd1];
      end
    end
  end

  // ****************************************************************
  // interrupt acknowledge
  // ****************************************************************
  // acknowledge stands one cycle; vector holds until the next
  always @(posedge clock) begin
    if (rst) begin
      irq_ack    <= 1'b0;
      irq_vector <= `PMV_VEC_RESET;
    end else begin
      irq_ack <= can_irq;
      if (can_irq) begin
        irq_vector <= vec_of(sel_slot);
      end
    end
  end

  // ****************************************************************
  // instruction fetch
  // ****************************************************************
  // the cycle after an acknowledge fetches from the vector
  always @(posedge clock) begin
    if (rst) begin
      fetch_addr <= `PMV_VEC_RESET;
      fetch_word <= {`PMV_DW{1'b0}};
    end else begin
      fetch_addr <= irq_ack ? irq_vector : next_pc;
      fetch_word <= mem_q[fetch_addr];
    end
  end

  // ****************************************************************
  // store load port
  // ****************************************************************
  // programming model of the one-time store
  always @(posedge clock) begin
    if (prog_we) begin
      mem_q[prog_addr] <= prog_data;
    end
  end

  // ****************************************************************
  // table read, two cycles
  // ****************************************************************
  localparam TS_IDLE = 2'b01;
  localparam TS_XFER = 2'b10;
  reg  [1:0]         tab_state_q;
  reg  [1:0]         tab_state_d;
  reg  [`PMV_AW-1:0] tab_addr_q;
  reg  [`PMV_AW-1:0] tab_addr_d;
  reg  [7:0]         dest_q;
  reg  [7:0]         dest_d;
  wire [`PMV_DW-1:0] tab_word_w;
  wire               tab_start_w;

  assign tab_busy    = tab_state_q[1];
  assign tab_start_w = tab_cur_op | tab_last_op;
  assign tab_word_w  = mem_q[tab_addr_q];

  // current-page request wins when both arrive together
  always @* begin
    tab_state_d = tab_state_q;
    tab_addr_d  = tab_addr_q;
    dest_d      = dest_q;
    case (tab_state_q)
      TS_IDLE: begin
        if (tab_start_w) begin
          dest_d      = tab_dest;
          tab_state_d = TS_XFER;
        end
        if (tab_cur_op) begin
          tab_addr_d = {tbl_ptr_hi, tbl_ptr_lo};
        end else if (tab_last_op) begin
          tab_addr_d = {`PMV_LAST_PAGE, tbl_ptr_lo};
        end
      end
      TS_XFER: begin
        // requests here are ignored
        tab_state_d = TS_IDLE;
      end
      default: begin
        tab_state_d = TS_IDLE;
      end
    endcase
  end

  // table state registers
  always @(posedge clock) begin
    if (rst) begin
      tab_state_q <= TS_IDLE;
      tab_addr_q  <= `PMV_VEC_RESET;
      dest_q      <= 8'h00;
    end else begin
      tab_state_q <= tab_state_d;
      tab_addr_q  <= tab_addr_d;
      dest_q      <= dest_d;
    end
  end

  // only table reads touch the high latch
  always @(posedge clock) begin
    if (rst) begin
      dmem_we               <= 1'b0;
      dmem_addr             <= 8'h00;
      dmem_data             <= 8'h00;
      table_high_byte_latch <= 8'h00;
    end else begin
      dmem_we <= tab_busy;
      if (tab_busy) begin
        dmem_addr             <= dest_q;
        dmem_data             <= tab_word_w[7:0];
        table_high_byte_latch <= tab_word_w[15:8]
                                 & HIGH_MASK[7:0];
      end
    end
  end

endmodule // pmv_core

//--- rtl/pmv_consts.vh
// constants for the program store, vector and table read block
`ifndef PMV_CONSTS_VH
`define PMV_CONSTS_VH
`define PMV_DEPTH          49152
`define PMV_AW             16
`define PMV_DW             16
`define PMV_NSRC           18
`define PMV_VEC_RESET      16'h0000
`define PMV_VEC_SCARD      16'h0004
`define PMV_VEC_USB        16'h0008
`define PMV_VEC_EXT0       16'h000C
`define PMV_VEC_EXT1       16'h0010
`define PMV_VEC_TMR0       16'h0014
`define PMV_VEC_TMR1       16'h0018
`define PMV_VEC_CARDDET    16'h001C
`define PMV_VEC_ADC        16'h0020
`define PMV_VEC_MF0        16'h0024
`define PMV_VEC_MF1        16'h0028
`define PMV_LAST_PAGE      8'hBF
`define PMV_HIGH_MASK      8'hFF
`define PMV_STACK_DEPTH    16
`define PMV_STACK_IW       5
`endif

//--- tb/pmv_core_sva.sv
// assertion checker for the program store block
`timescale 1ns/10ps
module pmv_core_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        insn_boundary,
  input wire logic        tab_cur_op,
  input wire logic        tab_last_op,
  input wire logic [7:0]  tab_dest,
  input wire logic [15:0] fetch_addr,
  input wire logic        irq_ack,
  input wire logic [15:0] irq_vector,
  input wire logic        stack_full,
  input wire logic        tab_busy,
  input wire logic        dmem_we,
  input wire logic [7:0]  dmem_addr,
  input wire logic [7:0]  table_high_byte_latch
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence tab_go_s;
    (tab_cur_op || tab_last_op) && !tab_busy;
  endsequence
  sequence tab_done_s;
    tab_busy ##1 dmem_we;
  endsequence
  reset_vec_a: assert property ($fell(rst) |-> fetch_addr == 16'h0000)
    else $error("fetch not at zero after reset");
  tab_two_a: assert property (tab_go_s |=> tab_done_s)
    else $error("table read not two cycles");
  tab_dest_a: assert property (tab_go_s |-> ##2 dmem_addr == $past(tab_dest, 2))
    else $error("table destination wrong");
  latch_ro_a: assert property ($changed(table_high_byte_latch) |-> dmem_we)
    else $error("high latch changed outside table read");
  ack_full_a: assert property (irq_ack |-> !$past(stack_full))
    else $error("interrupt taken on full stack");
  ack_bound_a: assert property (irq_ack |-> $past(insn_boundary && !tab_busy))
    else $error("interrupt taken mid instruction");
  ack_fetch_a: assert property (irq_ack |=> fetch_addr == irq_vector)
    else $error("vector not fetched after ack");
  vec_range_a: assert property (irq_ack |-> irq_vector[1:0] == 2'h0 &&
    irq_vector >= 16'h0004 && irq_vector <= 16'h0028)
    else $error("vector outside table");
endmodule // pmv_core_sva
bind pmv_core pmv_core_sva u_sva (.*);

//--- tb/pmv_cpu.sv
// core fetch stand-in: instruction boundary and return address
`timescale 1ns/10ps
module pmv_cpu (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic        tab_busy,
  input  wire logic [15:0] fetch_addr,
  output logic             insn_boundary,
  output logic [15:0]      next_pc
);
  logic odd_q = 1'b0;
  always_ff @(posedge clock) odd_q <= ~odd_q;
  // no boundary inside a table read, every other cycle when slow
  assign insn_boundary = !tab_busy && !(slow && odd_q);
  assign next_pc = fetch_addr + 16'h0001;
endmodule // pmv_cpu

//--- tb/pmv_core_test.sv
// self-checking bench for the program store block
`timescale 1ns/10ps
module pmv_core_test;
  logic        clock, rst, prog_we, call_op, return_op, slow, insn_boundary;
  logic        return_from_interrupt_op, tab_cur_op, tab_last_op, irq_ack;
  logic        return_valid, stack_full, tab_busy, dmem_we;
  logic [15:0] prog_addr, prog_data, next_pc, fetch_addr, fetch_word;
  logic [15:0] irq_vector, return_pc, w;
  logic [17:0] irq_event, irq_enable;
  logic [7:0]  tab_dest, tbl_ptr_lo, tbl_ptr_hi, dmem_addr, dmem_data;
  logic [7:0]  table_high_byte_latch;
  int          errors, checks, nack, seed, i, n0;
  pmv_core i_dut (.*);
  pmv_cpu i_cpu (.clock(clock), .slow(slow), .tab_busy(tab_busy),
    .fetch_addr(fetch_addr), .insn_boundary(insn_boundary), .next_pc(next_pc));
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (irq_ack === 1'b1) nack++;
  task automatic tick(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic reset;
    rst = 1;
    tick(6);
    rst = 0;
    chk("fetch_addr", 16'h0000, fetch_addr);
  endtask
  function automatic logic [15:0] vec(int s);
    return s < 8 ? 16'(4 * s + 4) : (s < 12 ? 16'h0024 : 16'h0028);
  endfunction
  task automatic fire(logic [17:0] ev);
    irq_event = ev;
    tick(1);
    irq_event = 0;
  endtask
  task automatic wack(logic [15:0] e);
    int k;
    logic [15:0] rp;
    k = 0;
    while (irq_ack !== 1'b1 && k < 12) begin
      tick(1);
      k++;
    end
    chk("irq_ack", 1, irq_ack);
    chk("irq_vector", e, irq_vector);
    rp = fetch_addr;
    return_from_interrupt_op = 1;
    tick(1);
    return_from_interrupt_op = 0;
    chk("return_valid", 1, return_valid);
    chk("return_pc", rp, return_pc);
  endtask
  task automatic tab(logic last);
    logic [15:0] ad;
    tbl_ptr_lo = $random(seed);
    tbl_ptr_hi = 8'({$random(seed)} % 192);
    tab_dest = $random(seed);
    w = $random(seed);
    ad = last ? {8'hBF, tbl_ptr_lo} : {tbl_ptr_hi, tbl_ptr_lo};
    prog_we = 1;
    prog_addr = ad;
    prog_data = w;
    tick(1);
    prog_we = 0;
    tab_cur_op = !last;
    tab_last_op = last;
    tick(1);
    tab_cur_op = 0;
    tab_last_op = 0;
    chk("tab_busy", 1, tab_busy);
    tick(1);
    chk("dmem_we", 1, dmem_we);
    chk("dmem_addr", tab_dest, dmem_addr);
    chk("dmem_data", w[7:0], dmem_data);
    chk("high_latch", w[15:8], table_high_byte_latch);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {rst, prog_we, call_op, return_op, return_from_interrupt_op, slow} = 0;
    {tab_cur_op, tab_last_op, prog_addr, prog_data, irq_event} = 0;
    {irq_enable, tab_dest, tbl_ptr_lo, tbl_ptr_hi, errors, checks} = 0;
    nack = 0;
    seed = 32'h9F1D;
    prog_we = 1;
    prog_data = 16'h5A3C;
    reset;
    prog_we = 0;
    tick(1);
    chk("fetch_word", 16'h5A3C, fetch_word);
    chk("fetch_addr", 16'h0001, fetch_addr);
    for (i = 0; i < 16; i++) tab(i[0]);
    irq_enable = '1;
    for (i = 0; i < 15; i++) begin
      slow = i[0];
      fire(18'(1) << i);
      wack(vec(i));
    end
    fire(18'h02084);
    for (i = 0; i < 3; i++) wack(i == 0 ? 16'h000C : 16'(24 + 8 * i));
    reset;
    irq_enable = 18'h00200;
    fire(18'h00100);
    n0 = nack;
    tick(8);
    chk("masked_acks", 16'(n0), 16'(nack));
    fire(18'h00200);
    wack(16'h0024);
    reset;
    irq_enable = '1;
    call_op = 1;
    tick(16);
    call_op = 0;
    chk("stack_full", 1, stack_full);
    fire(18'h00001);
    n0 = nack;
    tick(8);
    chk("full_acks", 16'(n0), 16'(nack));
    return_op = 1;
    tick(1);
    return_op = 0;
    wack(16'h0004);
    summarize;
  end
  initial begin
    #200us;
    errors++;
    summarize;
  end
endmodule // pmv_core_test
